// >>> core/lom_pkg.sv
// package for the load overvoltage monitor: register offset, fields, reset values, timing
// assumes a single 250 MHz system clock
package lom_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] LIMIT_OFFSET     = 8'h33;
  localparam logic [7:0] LIMIT_RESET      = 8'h00;
  localparam int         CODE_MSB         = 7;
  localparam int         CODE_LSB         = 3;
  localparam int         REG_POINT_BIT    = 2;
  localparam int         SAMPLES_MSB      = 1;
  localparam int         SAMPLES_LSB      = 0;
  // ----------------------------------------
  // threshold arithmetic
  // ----------------------------------------
  localparam logic [6:0] CODE_BASE        = 7'h59;  // 89
  localparam int         THR_DIV_LOG2     = 7;      // divide by 128
  localparam int         FULL_SCALE_MV    = 1550;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_MHZ          = 250;
  localparam int         SAMPLE_PERIOD_US = 80;
  localparam int         SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_MHZ;
endpackage : lom_pkg

// >>> core/lom_monitor.sv
// load overvoltage monitor: limit register, threshold, sample tick, consecutive-sample filter
// assumes a register port from the serial management block and averaged sense words from the adc path
`timescale 1ns/10ps
// What this block does
// - threshold equals (89 + code)/128 times 1.55 V full scale
// - code 0 gives 107.7 percent, code 31 gives 145.3 percent, 1.21 percent steps
// - code in bits 7:3, one code shared by both load sense channels
// - regulating-point bit set selects remote sense always, else local during soft start/switch
// - flag raised when an 80 us period average exceeds the threshold
// - multi-sample setting needs every consecutive period above threshold
// - sample code 00 means one over-threshold period sets the flag
// - codes 01, 10, 11 need two, three, four periods
module lom_monitor #(
  parameter int ADC_W         = 12,
  parameter int SAMPLE_CYCLES = lom_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RESET,
  // register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic             REG_WR,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  // sense inputs, full scale of the word equals 1.55 V
  input  wire logic [ADC_W-1:0] LOAD_SENSE_SECONDARY,
  input  wire logic [ADC_W-1:0] REMOTE_SENSE_NODE,
  input  wire logic [ADC_W-1:0] LOCAL_SENSE_NODE,
  // regulation state
  input  wire logic             SOFT_START_ACTIVE,
  input  wire logic             ORING_SWITCH_OFF,
  output logic                  USE_REMOTE_SENSE,
  // protection
  output logic [ADC_W-1:0]      OVP_THRESHOLD,
  output logic                  OVERVOLTAGE_FLAG,
  input  wire logic             OVERVOLTAGE_CLEAR,
  output logic                  SAMPLE_TICK
);
  localparam int CW  = $clog2(SAMPLE_CYCLES + 1);
  localparam int SW  = ADC_W + $clog2(SAMPLE_CYCLES + 1);
  localparam int NCH = 2;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // one offset is mapped; writes elsewhere are dropped and reads elsewhere return zero
  logic limit_sel;
  logic limit_wr;

  assign limit_sel = (REG_ADDR == lom_pkg::LIMIT_OFFSET);
  assign limit_wr  = REG_WR && limit_sel;

  // ----------------------------------------
  // limit register
  // ----------------------------------------
  logic [7:0] limit_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      limit_q <= lom_pkg::LIMIT_RESET;
    end else if (limit_wr) begin
      limit_q <= REG_WDATA;
    end
  end

  // read data is registered, so it answers one cycle after the address
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (limit_sel) begin
      REG_RDATA <= limit_q;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // register fields
  // ----------------------------------------
  logic [4:0] code;
  logic       reg_point;
  logic [1:0] samples;

  assign code      = limit_q[lom_pkg::CODE_MSB:lom_pkg::CODE_LSB];
  assign reg_point = limit_q[lom_pkg::REG_POINT_BIT];
  assign samples   = limit_q[lom_pkg::SAMPLES_MSB:lom_pkg::SAMPLES_LSB];

  // ----------------------------------------
  // regulating point
  // ----------------------------------------
  // the switch condition is taken as "oring switch off"; that state is not pinned down further
  logic local_phase;

  assign local_phase = SOFT_START_ACTIVE || ORING_SWITCH_OFF;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      USE_REMOTE_SENSE <= 1'b0;
    end else begin
      USE_REMOTE_SENSE <= reg_point || !local_phase;
    end
  end

  // ----------------------------------------
  // threshold
  // ----------------------------------------
  // sense words span the full scale, so threshold word = (89 + code) * 2^ADC_W / 128
  // limitation: ADC_W below 7 cannot hold one threshold step
  logic [6:0]       thr_base;
  logic [ADC_W+6:0] thr_wide;

  assign thr_base = 7'({2'b00, code} + lom_pkg::CODE_BASE);
  assign thr_wide = (ADC_W+7)'(thr_base) << (ADC_W - lom_pkg::THR_DIV_LOG2);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      OVP_THRESHOLD <= '0;
    end else begin
      OVP_THRESHOLD <= thr_wide[ADC_W-1:0];
    end
  end

  // ----------------------------------------
  // 80 us sampling tick
  // ----------------------------------------
  logic [CW-1:0] tick_cnt_q;
  logic          period_end;

  // the last count closes a period; the tick is registered so it trails that edge by one
  assign period_end = (tick_cnt_q == CW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tick_cnt_q <= '0;
    end else if (period_end) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + CW'(1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      SAMPLE_TICK <= 1'b0;
    end else begin
      SAMPLE_TICK <= period_end;
    end
  end

  // ----------------------------------------
  // period averaging, both load channels share one threshold
  // ----------------------------------------
  // sums are compared against threshold*cycles, which avoids a divider
  logic [SW-1:0]    sum_limit;
  logic [ADC_W-1:0] chan_sample [NCH];
  logic [NCH-1:0]   chan_over;
  logic             over;

  assign sum_limit      = SW'(OVP_THRESHOLD) * SW'(SAMPLE_CYCLES);
  assign chan_sample[0] = LOAD_SENSE_SECONDARY;
  assign chan_sample[1] = REMOTE_SENSE_NODE;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    logic [SW-1:0] sum_q;

    // the closing cycle's word seeds the next sum, so each full period holds SAMPLE_CYCLES words
    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        sum_q <= '0;
      end else if (period_end) begin
        sum_q <= SW'(chan_sample[ch]);
      end else begin
        sum_q <= sum_q + SW'(chan_sample[ch]);
      end
    end

    assign chan_over[ch] = (sum_q > sum_limit);
  end

  // either channel above the shared limit marks the period as over
  assign over = |chan_over;

  // ----------------------------------------
  // consecutive-period filter
  // ----------------------------------------
  // the run saturates at four, the largest count the field can ask for
  logic [2:0] run_q;
  logic [2:0] need;

  assign need = {1'b0, samples} + 3'h1;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      run_q <= 3'h0;
    end else if (period_end) begin
      if (!over) begin
        run_q <= 3'h0;
      end else if (run_q < 3'h4) begin
        run_q <= run_q + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // sticky flag
  // ----------------------------------------
  // a trip beats a clear in the same cycle, so no over-threshold period is lost
  logic trip;

  assign trip = period_end && over && ((run_q + 3'h1) >= need);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      OVERVOLTAGE_FLAG <= 1'b0;
    end else if (trip) begin
      OVERVOLTAGE_FLAG <= 1'b1;
    end else if (OVERVOLTAGE_CLEAR) begin
      OVERVOLTAGE_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------
  // unused inputs
  // ----------------------------------------
  // the local sense word feeds the local limits, which live outside this block
  logic local_unused;

  assign local_unused = ^LOCAL_SENSE_NODE;

endmodule : lom_monitor

// >>> dv/lom_ovp_monitor.sv
// checker for the load overvoltage monitor ports
// assumes the bench shortens the sample period to 8 cycles
`timescale 1ns/10ps
module lom_ovp_chk #(parameter int SAMPLE_CYCLES = 8) (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        SOFT_START_ACTIVE,
  input wire logic        ORING_SWITCH_OFF,
  input wire logic        USE_REMOTE_SENSE,
  input wire logic [11:0] OVP_THRESHOLD,
  input wire logic        OVERVOLTAGE_FLAG,
  input wire logic        OVERVOLTAGE_CLEAR,
  input wire logic        SAMPLE_TICK
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  wire logic wa = REG_WR && REG_ADDR == 8'h33;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  chk_thr_value: assert property (wa ##1 !wa |=>
    OVP_THRESHOLD == 12'((8'h59 + ($past(REG_WDATA, 2) >> 3)) * 12'h020)) else $error("threshold wrong");
  chk_read_back: assert property (wa ##1 (REG_ADDR == 8'h33 && !REG_WR) |=>
    REG_RDATA == $past(REG_WDATA, 2)) else $error("readback wrong");
  chk_unmapped_zero: assert property (REG_ADDR != 8'h33 |=> REG_RDATA == 8'h00) else $error("unmapped read");
  chk_local_sense: assert property (!USE_REMOTE_SENSE && !$past(RESET) |->
    $past(SOFT_START_ACTIVE || ORING_SWITCH_OFF)) else $error("local sense chosen");
  // period fixed at 8 because the bench sets SAMPLE_CYCLES to 8
  chk_tick_period: assert property (SAMPLE_TICK |=> !SAMPLE_TICK [*7] ##1 SAMPLE_TICK) else $error("tick");
  chk_flag_tick: assert property ($rose(OVERVOLTAGE_FLAG) |-> SAMPLE_TICK) else $error("flag off tick");
  chk_flag_sticky: assert property (OVERVOLTAGE_FLAG && !OVERVOLTAGE_CLEAR |=> OVERVOLTAGE_FLAG) else $error("flag");
  chk_reset_state: assert property (disable iff (1'b0) RESET |=> !OVERVOLTAGE_FLAG && !SAMPLE_TICK)
    else $error("reset state");
endmodule : lom_ovp_chk
bind lom_monitor lom_ovp_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) lom_ovp_chk_inst (.*);

// >>> dv/tb.sv
// bench for the load overvoltage monitor: register port, threshold codes, sample filter
// assumes SAMPLE_CYCLES shortened to 8 so each period lasts 32 ns
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic        clk = 0, rst = 1, wr = 0, ss = 0, orf = 0, clr = 0, remote, flag, tick;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rd;
  logic [11:0] sec = 12'h000, rem = 12'h000, thr;
  int          failures = 0, total_checks = 0, n;
  logic [4:0]  n_codes [3] = '{5'h00, 5'h0A, 5'h1F};
  always #2 clk = ~clk;
  lom_monitor #(.SAMPLE_CYCLES(8)) lom_monitor_inst (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wd), .REG_RDATA(rd), .LOAD_SENSE_SECONDARY(sec), .REMOTE_SENSE_NODE(rem),
    .LOCAL_SENSE_NODE(12'h000), .SOFT_START_ACTIVE(ss), .ORING_SWITCH_OFF(orf), .USE_REMOTE_SENSE(remote),
    .OVP_THRESHOLD(thr), .OVERVOLTAGE_FLAG(flag), .OVERVOLTAGE_CLEAR(clr), .SAMPLE_TICK(tick));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wd, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    `CHK(rd, e)
  endtask : rd_reg
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // odd sample codes use the remote channel, even the secondary: one code serves both
  task automatic run_flag(input int s);
    int k;
    wr_reg(8'h33, 8'(s));
    {sec, rem, clr} = {24'h0, 1'b1};
    repeat (24) @(negedge clk);
    clr = 0;
    for (k = 0; k < 9 && !tick; k++) @(negedge clk);
    if (!tick) begin
      failures++;
      stop_test();
    end
    if (s % 2) rem = 12'hFFF; else sec = 12'hFFF;
    n = 0;
    for (k = 0; k < 60 && !flag; k++) begin
      @(negedge clk);
      n += tick;
    end
    `CHK(n, s + 1)
    if (k == 60) begin
      failures++;
      stop_test();
    end
  endtask : run_flag
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    rd_reg(8'h33, 8'h00);
    wr_reg(8'h34, 8'hFF);
    rd_reg(8'h34, 8'h00);
    foreach (n_codes[i]) begin
      wr_reg(8'h33, {n_codes[i], 3'h5});
      rd_reg(8'h33, {n_codes[i], 3'h5});
      `CHK(thr, 12'((89 + n_codes[i]) * 32))
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h33, {5'h00, i[1], 2'h0});
      orf = i[0];
      ss = i[2];
      repeat (2) @(negedge clk);
      `CHK(remote, i[1] | !(i[0] | i[2]))
    end
    orf = 0;
    ss = 0;
    for (int s = 0; s < 4; s++) run_flag(s);
    stop_test();
  end
endmodule : tb
